// ### hdl/pfb_pkg.sv
// Purpose : Shared constants and types of the filter B control and insertion port block.
// Assumes : One 125 MHz clock, microcontroller strobes synchronous to it.
// Notes   : Offsets are byte addresses on the microcontroller register port.
package pfb_pkg;

    // ************************************************************
    // Register map
    // ************************************************************
    localparam logic [11:0] PFB_TABLE_PORT_OFS = 12'h0dc;
    localparam logic [11:0] PFB_CSR_OFS        = 12'h0e0;
    localparam logic [11:0] PFB_INS_PORT_OFS   = 12'h0e4;

    // ************************************************************
    // Control and status field layout
    // ************************************************************
    localparam int          PFB_EN_BIT    = 0;
    localparam int          PFB_CLR_BIT   = 1;
    localparam int          PFB_BUF_LSB   = 4;
    localparam int          PFB_WPTR_LSB  = 8;
    localparam int          PFB_RPTR_LSB  = 12;
    localparam logic [31:0] PFB_RSVD_MASK = 32'hffff_008e;

    // ************************************************************
    // Reset values and sizes
    // ************************************************************
    localparam logic [31:0] PFB_CSR_RESET   = 32'h0000_0000;
    localparam logic [31:0] PFB_TABLE_RESET = 32'h0000_0000;
    localparam int          PFB_DATA_W      = 32;
    localparam int          PFB_PID_W       = 13;
    localparam int          PFB_BUF_W       = 3;
    localparam int          PFB_TABLE_DEPTH = 16;
    localparam int          PFB_INS_DEPTH   = 64;
    localparam int          PFB_FIFO_DEPTH  = 32;

    // Packet disposition of the stream input.
    typedef enum logic [2:0] {
        PFB_ST_IDLE = 3'b001,
        PFB_ST_PASS = 3'b010,
        PFB_ST_DROP = 3'b100
    } pfb_state_t;

endpackage : pfb_pkg

// ### hdl/pfb_fifo_if.sv
// Purpose : Carries the push and pop handshakes between the filter and its FIFO.
// Assumes : Both sides on mclk.
// Notes   : Width is a parameter so the buffer number can ride with the data.
`timescale 1ns/10ps
interface pfb_fifo_if #(parameter int WIDTH = 35);
    logic             push_valid;
    logic             push_ready;
    logic [WIDTH-1:0] push_data;
    logic             pop_valid;
    logic             pop_ready;
    logic [WIDTH-1:0] pop_data;

    modport client (output push_valid, push_data, pop_ready,
                    input  push_ready, pop_valid, pop_data);
    modport store  (input  push_valid, push_data, pop_ready,
                    output push_ready, pop_valid, pop_data);
endinterface : pfb_fifo_if

// ### hdl/pfb_fifo.sv
// Purpose : Synchronous FIFO with a registered output stage.
// Assumes : Push and pop on the same clock.
// Notes   : Ready and valid both come from flip-flops; DEPTH words sit in memory.
`timescale 1ns/10ps
module pfb_fifo #(
    parameter int WIDTH = 35,
    parameter int DEPTH = 32
) (
    input wire logic    mclk,
    input wire logic    nrst,
    pfb_fifo_if.store   fifo
);
    import pfb_pkg::*;

    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [CW-1:0]    count;
    logic [CW-1:0]    next_count;
    logic             full;
    logic             out_valid;
    logic [WIDTH-1:0] out_data;
    logic             push;
    logic             load;

    // ************************************************************
    // Handshake decode
    // ************************************************************
    // The output stage reloads whenever memory holds a word and the stage is empty or being drained.
    assign push       = fifo.push_valid && !full;
    assign load       = (count != '0) && (!out_valid || fifo.pop_ready);
    assign next_count = CW'(count + CW'(push) - CW'(load));

    assign fifo.push_ready = !full;
    assign fifo.pop_valid  = out_valid;
    assign fifo.pop_data   = out_data;

    // Storage array is not reset; only words behind valid pointers are read.
    always_ff @(posedge mclk) begin
        if (push) begin
            mem[wr_ptr] <= fifo.push_data;
        end
    end

    // Pointers, level and full flag; full is a flop so the source sees a clean ready.
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
            full   <= 1'b0;
        end else begin
            if (push) begin
                wr_ptr <= AW'(wr_ptr + 1'b1);
            end
            if (load) begin
                rd_ptr <= AW'(rd_ptr + 1'b1);
            end
            count <= next_count;
            full  <= (next_count == CW'(DEPTH));
        end
    end

    // Output register holds the head word until the sink takes it.
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            out_valid <= 1'b0;
            out_data  <= '0;
        end else if (load) begin
            out_valid <= 1'b1;
            out_data  <= mem[rd_ptr];
        end else if (fifo.pop_ready) begin
            out_valid <= 1'b0;
        end
    end

endmodule : pfb_fifo

// ### hdl/pfb_filter.sv
// Purpose : Filter B control and status, filter table port, insertion RAM port, PID gate.
// Assumes : Microcontroller strobes and stream input are synchronous to mclk.
// Notes   : One register access per cycle; read data returns one cycle after the strobe.
`timescale 1ns/10ps

// How it works
// - Filter table reads advance read pointer when disabled.
// - Enabling the filter zeroes the read pointer.
// - Reads while enabled leave read pointer alone.
// - Filter table writes advance write pointer when disabled.
// - Write pointer held zero while filter enabled.
// - Status shows buffer taking selected packets.
// - Filter clear zeroes table and both pointers.
// - Enabled filter passes only packets with matching identifier.
// - Reserved control bits ignore writes, read zero.
// - Insertion port writes store word at write pointer.
// - Each insertion write while insertion disabled advances insertion write pointer.
// - Insertion port does nothing while insertion enabled.
// - Insertion RAM is not initialised at reset.
// - Table port reads read-pointer entry, writes write-pointer entry.
module pfb_filter
    import pfb_pkg::*;
#(
    parameter int TABLE_DEPTH = pfb_pkg::PFB_TABLE_DEPTH,
    parameter int INS_DEPTH   = pfb_pkg::PFB_INS_DEPTH,
    parameter int FIFO_DEPTH  = pfb_pkg::PFB_FIFO_DEPTH
) (
    input  wire logic                                   mclk,
    input  wire logic                                   nrst,
    input  wire logic [11:0]                            reg_addr,
    input  wire logic                                   reg_wr,
    input  wire logic                                   reg_rd,
    input  wire logic [pfb_pkg::PFB_DATA_W-1:0]         reg_wdata,
    output logic      [pfb_pkg::PFB_DATA_W-1:0]         reg_rdata,
    output logic                                        reg_rvalid,
    input  wire logic                                   ins_enable,
    input  wire logic [pfb_pkg::PFB_TABLE_DEPTH*pfb_pkg::PFB_BUF_W-1:0] location_buffer_map,
    input  wire logic                                   ts_valid,
    input  wire logic                                   ts_first,
    input  wire logic [pfb_pkg::PFB_PID_W-1:0]          ts_pid,
    input  wire logic [pfb_pkg::PFB_DATA_W-1:0]         ts_data,
    output logic                                        ts_ready,
    output logic                                        tx_valid,
    output logic      [pfb_pkg::PFB_DATA_W-1:0]         tx_data,
    output logic      [pfb_pkg::PFB_BUF_W-1:0]          tx_buffer,
    input  wire logic                                   tx_ready,
    output logic                                        filter_enable,
    output logic      [$clog2(pfb_pkg::PFB_INS_DEPTH)-1:0] ins_wr_ptr,
    output logic      [$clog2(pfb_pkg::PFB_INS_DEPTH)-1:0] ins_rd_ptr
);
    import pfb_pkg::*;

    localparam int TW = $clog2(TABLE_DEPTH);
    localparam int IW = $clog2(INS_DEPTH);
    localparam int FW = PFB_DATA_W + PFB_BUF_W;

    // ************************************************************
    // Storage and state
    // ************************************************************
    logic [PFB_DATA_W-1:0] filter_table [TABLE_DEPTH];
    logic [PFB_DATA_W-1:0] ins_ram [INS_DEPTH];
    logic [TW-1:0]         table_read_pointer;
    logic [TW-1:0]         table_write_pointer;
    logic [PFB_BUF_W-1:0]  selected_data_buffer;
    logic                  clear_pending;
    logic                  ins_enable_q;
    pfb_state_t            state;
    pfb_state_t            next_state;

    logic                  csr_wr;
    logic                  csr_rd;
    logic                  tbl_wr;
    logic                  tbl_rd;
    logic                  ins_wr;
    logic                  ins_rd;
    logic                  enable_set;
    logic                  ins_rise;
    logic                  hit;
    logic [PFB_BUF_W-1:0]  hit_buf;
    logic                  pass_now;
    logic                  ts_fire;
    logic [PFB_DATA_W-1:0] table_head;
    logic [PFB_DATA_W-1:0] csr_value;

    pfb_fifo_if #(.WIDTH(FW)) fq ();

    // ************************************************************
    // Register port decode
    // ************************************************************
    // Only whole-word accesses at the three offsets have any effect.
    assign csr_wr     = reg_wr && (reg_addr == PFB_CSR_OFS);
    assign csr_rd     = reg_rd && (reg_addr == PFB_CSR_OFS);
    assign tbl_wr     = reg_wr && (reg_addr == PFB_TABLE_PORT_OFS);
    assign tbl_rd     = reg_rd && (reg_addr == PFB_TABLE_PORT_OFS);
    assign ins_wr     = reg_wr && (reg_addr == PFB_INS_PORT_OFS);
    assign ins_rd     = reg_rd && (reg_addr == PFB_INS_PORT_OFS);
    assign enable_set = csr_wr && reg_wdata[PFB_EN_BIT] && !filter_enable;
    assign ins_rise   = ins_enable && !ins_enable_q;
    assign table_head = filter_table[table_read_pointer];

    // Reserved bits and the clear bit are constant zero in the read image.
    assign csr_value = {16'h0000,
                        table_read_pointer,
                        table_write_pointer,
                        1'b0,
                        selected_data_buffer,
                        2'b00,
                        1'b0,
                        filter_enable};

    // ************************************************************
    // Control bits
    // ************************************************************
    // Only the enable and clear bits are taken from a write; the rest are dropped.
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            filter_enable <= PFB_CSR_RESET[PFB_EN_BIT];
            clear_pending <= 1'b0;
        end else begin
            if (csr_wr) begin
                filter_enable <= reg_wdata[PFB_EN_BIT];
            end
            clear_pending <= csr_wr && reg_wdata[PFB_CLR_BIT];
        end
    end

    // ************************************************************
    // Filter table pointers
    // ************************************************************
    // A pending clear outranks every other pointer update.
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            table_read_pointer <= PFB_CSR_RESET[PFB_RPTR_LSB +: TW];
        end else if (clear_pending) begin
            table_read_pointer <= '0;
        end else if (enable_set) begin
            table_read_pointer <= '0;
        end else if (tbl_rd && !filter_enable) begin
            table_read_pointer <= TW'(table_read_pointer + 1'b1);
        end
    end

    // Zeroing on the enabling write keeps the pointer at zero from the first enabled cycle.
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            table_write_pointer <= PFB_CSR_RESET[PFB_WPTR_LSB +: TW];
        end else if (clear_pending) begin
            table_write_pointer <= '0;
        end else if (filter_enable || enable_set) begin
            table_write_pointer <= '0;
        end else if (tbl_wr) begin
            table_write_pointer <= TW'(table_write_pointer + 1'b1);
        end
    end

    // Comparison values reset to zero and are wiped again by a clear.
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < TABLE_DEPTH; i++) begin
                filter_table[i] <= PFB_TABLE_RESET;
            end
        end else if (clear_pending) begin
            for (int i = 0; i < TABLE_DEPTH; i++) begin
                filter_table[i] <= PFB_TABLE_RESET;
            end
        end else if (tbl_wr && !filter_enable) begin
            filter_table[table_write_pointer] <= reg_wdata;
        end
    end

    // ************************************************************
    // Insertion RAM port
    // ************************************************************
    // The array has no reset, so unwritten words read back undefined.
    always_ff @(posedge mclk) begin
        if (ins_wr && !ins_enable) begin
            ins_ram[ins_wr_ptr] <= reg_wdata;
        end
    end

    // Turning insertion on restarts both pointers for the hardware reader.
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            ins_enable_q <= 1'b0;
            ins_wr_ptr   <= '0;
            ins_rd_ptr   <= '0;
        end else begin
            ins_enable_q <= ins_enable;
            if (ins_rise) begin
                ins_wr_ptr <= '0;
                ins_rd_ptr <= '0;
            end else if (!ins_enable) begin
                if (ins_wr) begin
                    ins_wr_ptr <= IW'(ins_wr_ptr + 1'b1);
                end
                if (ins_rd) begin
                    ins_rd_ptr <= IW'(ins_rd_ptr + 1'b1);
                end
            end
        end
    end

    // ************************************************************
    // Read data
    // ************************************************************
    // Unmapped offsets and insertion reads while enabled return zero.
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            reg_rvalid <= 1'b0;
            reg_rdata  <= '0;
        end else begin
            reg_rvalid <= reg_rd;
            if (reg_rd) begin
                case (reg_addr)
                    PFB_CSR_OFS:        reg_rdata <= csr_value;
                    PFB_TABLE_PORT_OFS: reg_rdata <= table_head;
                    PFB_INS_PORT_OFS:   reg_rdata <= ins_enable ? '0 : ins_ram[ins_rd_ptr];
                    default:            reg_rdata <= '0;
                endcase
            end
        end
    end

    // ************************************************************
    // Identifier match and packet gate
    // ************************************************************
    // The lowest matching location wins, which fixes the buffer when entries repeat.
    always_comb begin
        hit     = 1'b0;
        hit_buf = '0;
        for (int i = TABLE_DEPTH - 1; i >= 0; i--) begin
            if (filter_table[i][PFB_PID_W-1:0] == ts_pid) begin
                hit     = 1'b1;
                hit_buf = location_buffer_map[i*PFB_BUF_W +: PFB_BUF_W];
            end
        end
    end

    // The decision is made on the first word and held for the whole packet.
    assign ts_fire  = ts_valid && ts_ready;
    assign pass_now = ts_first ? (!filter_enable || hit) : (state == PFB_ST_PASS);

    always_comb begin
        next_state = state;
        if (ts_fire && ts_first) begin
            next_state = pass_now ? PFB_ST_PASS : PFB_ST_DROP;
        end
        case (state)
            PFB_ST_IDLE: ;
            PFB_ST_PASS: ;
            PFB_ST_DROP: ;
            default:     next_state = PFB_ST_IDLE;
        endcase
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            state <= PFB_ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // The buffer number is latched from the location that opened the packet, so that packet's first word still carries the previous number.
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            selected_data_buffer <= PFB_CSR_RESET[PFB_BUF_LSB +: PFB_BUF_W];
        end else if (ts_fire && ts_first && filter_enable && hit) begin
            selected_data_buffer <= hit_buf;
        end
    end

    // ************************************************************
    // Transmit FIFO
    // ************************************************************
    // Dropped words are still consumed, but only while the FIFO has room.
    assign fq.push_valid = ts_valid && pass_now;
    assign fq.push_data  = {selected_data_buffer, ts_data};
    assign fq.pop_ready  = tx_ready;
    assign ts_ready      = fq.push_ready;
    assign tx_valid      = fq.pop_valid;
    assign tx_data       = fq.pop_data[PFB_DATA_W-1:0];
    assign tx_buffer     = fq.pop_data[FW-1:PFB_DATA_W];

    pfb_fifo #(
        .WIDTH (FW),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .mclk (mclk),
        .nrst (nrst),
        .fifo (fq.store)
    );

    // ************************************************************
    // Checks
    // ************************************************************
    sequence clear_req_s;
        csr_wr && reg_wdata[PFB_CLR_BIT];
    endsequence

    sequence clear_done_s;
        table_read_pointer == '0 && table_write_pointer == '0 && filter_table[0] == '0;
    endsequence

    read_advance_a: assert property (@(posedge mclk) disable iff (!nrst)
        tbl_rd && !filter_enable && !clear_pending
        |=> table_read_pointer == TW'($past(table_read_pointer) + 1'b1))
        else $error("Table read pointer did not advance.");

    enable_zero_a: assert property (@(posedge mclk) disable iff (!nrst)
        enable_set |=> table_read_pointer == '0 && filter_enable)
        else $error("Read pointer not zeroed on enable.");

    read_hold_a: assert property (@(posedge mclk) disable iff (!nrst)
        tbl_rd && filter_enable && !clear_pending |=> $stable(table_read_pointer))
        else $error("Read pointer moved while filter enabled.");

    write_advance_a: assert property (@(posedge mclk) disable iff (!nrst)
        tbl_wr && !filter_enable && !clear_pending
        |=> table_write_pointer == TW'($past(table_write_pointer) + 1'b1)
            && filter_table[$past(table_write_pointer)] == $past(reg_wdata))
        else $error("Table write did not store and advance.");

    write_zero_a: assert property (@(posedge mclk) disable iff (!nrst)
        filter_enable |-> table_write_pointer == '0)
        else $error("Write pointer nonzero while enabled.");

    buffer_latch_a: assert property (@(posedge mclk) disable iff (!nrst)
        ts_fire && ts_first && filter_enable && hit |=> selected_data_buffer == $past(hit_buf))
        else $error("Selected buffer not taken from matching location.");

    clear_action_a: assert property (@(posedge mclk) disable iff (!nrst)
        clear_req_s |=> clear_pending ##1 clear_done_s)
        else $error("Filter clear did not empty table and pointers.");

    drop_gate_a: assert property (@(posedge mclk) disable iff (!nrst)
        ts_fire && ts_first && filter_enable && !hit |=> state == PFB_ST_DROP
            ##0 (!fq.push_valid || ts_first))
        else $error("Unmatched packet reached the FIFO.");

    reserved_zero_a: assert property (@(posedge mclk) disable iff (!nrst)
        csr_rd |=> reg_rvalid && (reg_rdata & PFB_RSVD_MASK) == '0)
        else $error("Reserved or clear bits read nonzero.");

    ins_store_a: assert property (@(posedge mclk) disable iff (!nrst)
        ins_wr && !ins_enable && ins_enable_q == ins_enable
        |=> ins_ram[$past(ins_wr_ptr)] == $past(reg_wdata))
        else $error("Insertion word not stored.");

    ins_advance_a: assert property (@(posedge mclk) disable iff (!nrst)
        ins_wr && !ins_enable |=> ins_wr_ptr == IW'($past(ins_wr_ptr) + 1'b1))
        else $error("Insertion write pointer did not advance.");

    ins_ignore_a: assert property (@(posedge mclk) disable iff (!nrst)
        ins_enable && ins_enable_q && (ins_wr || ins_rd)
        |=> $stable(ins_wr_ptr) && $stable(ins_rd_ptr))
        else $error("Insertion access had effect while enabled.");

    table_read_a: assert property (@(posedge mclk) disable iff (!nrst)
        tbl_rd |=> reg_rvalid && reg_rdata == $past(table_head))
        else $error("Table port read returned wrong entry.");

    clear_oneshot_a: assert property (@(posedge mclk) disable iff (!nrst)
        clear_pending |-> $past(csr_wr) && $past(reg_wdata[PFB_CLR_BIT]))
        else $error("Clear pending without a clear write.");

endmodule : pfb_filter

// ### sim/test_pfb_filter.sv
// Purpose : Self-checking bench of the filter B control and insertion port block.
// Assumes : Register strobes and stream words change on the rising edge.
// Notes   : The sink is always ready, so the FIFO never fills in this run.
`timescale 1ns/10ps
module test_pfb_filter;
    import pfb_pkg::*;
    logic        mclk = 0, nrst = 0, reg_wr = 0, reg_rd = 0, ins_enable = 0;
    logic        ts_valid = 0, ts_first = 0, reg_rvalid, ts_ready, tx_valid, filter_enable;
    logic [11:0] reg_addr = 0;
    logic [31:0] reg_wdata = 0, ts_data = 0, reg_rdata, tx_data, d, s;
    logic [47:0] map = 0;
    logic [12:0] ts_pid = 0;
    logic [12:0] pid [3];
    logic [5:0]  ins_wr_ptr, ins_rd_ptr;
    logic [31:0] txq [$];
    logic [2:0]  txb, bq [$];
    int          mismatches = 0, num_checks = 0;

    pfb_filter i_dut (.mclk(mclk), .nrst(nrst), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .ins_enable(ins_enable), .location_buffer_map(map), .ts_valid(ts_valid),
        .ts_first(ts_first), .ts_pid(ts_pid), .ts_data(ts_data), .ts_ready(ts_ready),
        .tx_valid(tx_valid), .tx_data(tx_data), .tx_buffer(txb), .tx_ready(1'b1),
        .filter_enable(filter_enable), .ins_wr_ptr(ins_wr_ptr), .ins_rd_ptr(ins_rd_ptr));

    // The clock toggles every half period of 4 ns.
    always #4 mclk = ~mclk;

    // Words are logged mid-cycle, clear of the edge that launches them; the sink never stalls.
    always @(negedge mclk) begin
        if (tx_valid) begin
            txq.push_back(tx_data);
            bq.push_back(txb);
        end
    end

    // ****************************************************************
    // Shared tasks and expectations
    // ****************************************************************
    function automatic logic [31:0] csr(input int r, input int w, input logic [2:0] b);
        return {16'h0, 4'(r), 4'(w), 1'b0, b, 4'h0};
    endfunction : csr

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %0t: seen %h, expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic wr(input logic [11:0] a, input logic [31:0] v);
        @(posedge mclk) begin reg_wr <= 1; reg_addr <= a; reg_wdata <= v; end
        @(posedge mclk) reg_wr <= 0;
    endtask : wr

    // Read data is taken one settle step after the edge that raises valid.
    task automatic rd(input logic [11:0] a);
        @(posedge mclk) begin reg_rd <= 1; reg_addr <= a; end
        @(posedge mclk) reg_rd <= 0;
        #1 chk(reg_rvalid, 1);
        d = reg_rdata;
    endtask : rd

    task automatic send(input logic f, input logic [12:0] p, input logic [31:0] v);
        @(posedge mclk) begin ts_valid <= 1; ts_first <= f; ts_pid <= p; ts_data <= v; end
        @(posedge mclk) ts_valid <= 0;
    endtask : send

    task automatic print_verdict();
        $display("checks %0d, mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : print_verdict

    // Main sequence; table entries carry bit 12 so 0x0001 never matches.
    initial begin
        int n;
        void'($urandom(32));
        foreach (pid[i]) pid[i] = 13'h1000 | 13'($urandom);
        map = 48'({$urandom, $urandom}) | 48'h1; // Odd, so location 0 never maps to buffer 0.
        s = $urandom;
        repeat (16) @(posedge mclk);
        nrst <= 1;
        rd(PFB_CSR_OFS);
        chk(d, csr(0, 0, 0));
        foreach (pid[i]) wr(PFB_TABLE_PORT_OFS, 32'(pid[i]));
        rd(PFB_CSR_OFS);
        chk(d, csr(0, 3, 0));
        foreach (pid[i]) begin
            rd(PFB_TABLE_PORT_OFS);
            chk(d, 32'(pid[i]));
        end
        wr(PFB_CSR_OFS, PFB_RSVD_MASK & ~32'h2);
        rd(PFB_CSR_OFS);
        chk(d, csr(3, 3, 0));
        wr(PFB_CSR_OFS, 32'h1);
        wr(PFB_TABLE_PORT_OFS, 32'h5);
        rd(PFB_TABLE_PORT_OFS);
        chk(d, 32'(pid[0]));
        rd(PFB_CSR_OFS);
        chk(d, csr(0, 0, 0) | 32'h1);
        chk(filter_enable, 1);
        send(1, pid[0], s);
        send(0, 0, ~s);
        send(1, 13'h0001, 32'h1);
        send(0, 0, 32'h2);
        for (n = 0; txq.size() < 2 && n < 50; n++) @(posedge mclk);
        if (n == 50) mismatches++;
        repeat (8) @(posedge mclk);
        chk(32'(txq.size()), 2);
        chk(txq[0], s);
        chk(txq[1], ~s);
        chk(bq[1], map[2:0]);
        chk(ts_ready, 1);
        rd(PFB_CSR_OFS);
        chk(d, csr(0, 0, map[2:0]) | 32'h1);
        wr(PFB_CSR_OFS, 32'h0);
        wr(PFB_TABLE_PORT_OFS, s);
        rd(PFB_TABLE_PORT_OFS);
        chk(d, s);
        wr(PFB_CSR_OFS, 32'h2);
        rd(PFB_CSR_OFS);
        chk(d, csr(0, 0, map[2:0]));
        rd(PFB_TABLE_PORT_OFS);
        chk(d, 0);
        for (n = 0; n < 3; n++) wr(PFB_INS_PORT_OFS, s + n);
        #1 chk(ins_wr_ptr, 3);
        for (n = 0; n < 3; n++) begin
            rd(PFB_INS_PORT_OFS);
            chk(d, s + n);
        end
        @(posedge mclk) ins_enable <= 1;
        wr(PFB_INS_PORT_OFS, ~s);
        rd(PFB_INS_PORT_OFS);
        chk(ins_wr_ptr, 0);
        chk(ins_rd_ptr, 0);
        chk(d, 0);
        @(posedge mclk) ins_enable <= 0;
        rd(PFB_INS_PORT_OFS);
        chk(d, s);
        rd(12'h0f0);
        chk(d, 0);
        print_verdict();
    end
endmodule : test_pfb_filter
